// ===== ccm_top.sv
// Purpose: counter array capture/compare module with mode control
// Assumes: classic wishbone slave, sys_clk 20 MHz
// Notes: counter runs when the run bit is set, one step per enabled clock
`timescale 1ns/1ps
`include "ccm_defines.svh"
module ccm_top
    import ccm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic captureIn,
    output logic moduleOutputPin,
    output logic irq
);
    // --------------------------------------------------
    // registers
    // --------------------------------------------------
    mode_reg_t moduleModeReg;
    logic [15:0] cmpVal;
    logic [15:0] count;
    logic [15:0] capVal;
    logic [1:0] status;
    logic [1:0] mask;
    logic ack;
    logic [31:0] rdData;
    logic pinLevel;
    logic capPrev;
    mode_reg_t next_moduleModeReg;
    logic [15:0] next_cmpVal;
    logic [15:0] next_count;
    logic [15:0] next_capVal;
    logic [1:0] next_status;
    logic [1:0] next_mask;
    logic next_ack;
    logic [31:0] next_rdData;
    logic next_pinLevel;
    logic next_capPrev;
    logic fullHit;
    logic lowHit;
    logic tick;
    logic access;
    logic wrStb;
    logic hiBank;
    logic compareFlag;
    logic capEvent;
    logic pwmHit;
    logic wrapHit;
    out_mode_t outMode;
    logic maskWr;
    logic rdStb;
    logic cmpReq;
    logic capReq;

    // --------------------------------------------------
    // decode
    // --------------------------------------------------
    assign tick = moduleModeReg.countRun;
    // the !ack term keeps a strobe held through ack from being taken twice
    assign access = wb_cyc_i && wb_stb_i && !ack;
    assign wrStb = access && wb_we_i && wb_sel_i[0];
    assign hiBank = wb_sel_i[2] && !wb_sel_i[0];
    assign compareFlag = status[0];
    // mask sits in the third byte lane, so it has a strobe of its own
    assign maskWr = access && wb_we_i && wb_sel_i[2] && (wb_adr_i == `ADDR_MASK);
    assign rdStb = access && !wb_we_i;

    always_comb begin
        case ({moduleModeReg.toggleEnable, moduleModeReg.pwmEnable})
            2'b11: outMode = OUT_FREQ;
            2'b01: outMode = OUT_PWM;
            2'b10: outMode = OUT_TOGGLE;
            default: outMode = OUT_IDLE;
        endcase
    end

    // --------------------------------------------------
    // compare
    // --------------------------------------------------
    ccm_match u_match (
        .sysClk(sys_clk),
        .sysRst(sys_rst),
        .clkEn(clkEn),
        .tick(tick),
        .count(count),
        .value(cmpVal),
        .fullHit(fullHit),
        .lowHit(lowHit)
    );

    // --------------------------------------------------
    // pwm and capture
    // --------------------------------------------------
    // resolution select
    always_comb begin
        pwmHit = moduleModeReg.pwmWide ? fullHit : lowHit;
        // wrap reads the live count while the hits arrive a cycle late
        wrapHit = moduleModeReg.pwmWide ? (tick && count == `PWM_TOP_WIDE)
                                        : (tick && count[7:0] == `PWM_TOP_NARROW);
    end

    // capPrev tracks the pin even with capture off, so enabling sees no stale edge
    // falling and rising edge capture
    always_comb begin
        capEvent = (moduleModeReg.fallCapEn && capPrev && !captureIn)
                || (moduleModeReg.riseCapEn && !capPrev && captureIn);
    end

    // --------------------------------------------------
    // next state
    // --------------------------------------------------
    always_comb begin
        next_moduleModeReg = moduleModeReg;
        next_cmpVal = cmpVal;
        next_count = tick ? count + 16'h0001 : count;
        next_capVal = capEvent ? count : capVal;
        next_status = status;
        next_mask = mask;
        next_ack = access;
        next_rdData = 32'h0000_0000;
        next_pinLevel = pinLevel;
        next_capPrev = captureIn;
        if (wrStb) begin
            case ({hiBank, wb_adr_i})
                {1'b0, `ADDR_MODE}: next_moduleModeReg = mode_reg_t'(wb_dat_i[7:0]);
                {1'b0, `ADDR_CMPVAL}: next_cmpVal = wb_dat_i[15:0];
                {1'b0, `ADDR_COUNT}: next_count = wb_dat_i[15:0];
                {1'b0, `ADDR_STATUS}: next_status = status & ~wb_dat_i[1:0];
                default: ;
            endcase
        end
        if (maskWr) begin
            next_mask = wb_dat_i[17:16];
        end
        // match sets flag, set wins over clear
        if (fullHit && moduleModeReg.matchEnable) begin
            next_status[0] = 1'b1;
        end
        if (capEvent) begin
            next_status[1] = 1'b1;
        end
        case (outMode)
            OUT_TOGGLE: if (fullHit) next_pinLevel = !pinLevel;
            OUT_PWM: begin
                if (pwmHit) next_pinLevel = 1'b1;
                else if (wrapHit) next_pinLevel = 1'b0;
            end
            OUT_FREQ: if (lowHit) next_pinLevel = !pinLevel;
            OUT_IDLE: next_pinLevel = pinLevel;
            default: next_pinLevel = 1'b0;
        endcase
        if (rdStb) begin
            case (wb_adr_i)
                `ADDR_MODE: next_rdData = {14'h0000, mask, 8'h00, moduleModeReg};
                `ADDR_CMPVAL: next_rdData = {capVal, cmpVal};
                `ADDR_COUNT: next_rdData = {16'h0000, count};
                `ADDR_STATUS: next_rdData = {30'h0000_0000, status};
                default: next_rdData = 32'h0000_0000;
            endcase
        end
    end

    // clkEn low freezes every register, ack too, so a bus cycle simply stalls
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            moduleModeReg <= mode_reg_t'(`RST_MODE);
            cmpVal <= `RST_CMPVAL;
            count <= `RST_COUNT;
            capVal <= `RST_CAPVAL;
            status <= `RST_STATUS;
            mask <= `RST_MASK;
            ack <= 1'b0;
            rdData <= 32'h0000_0000;
            pinLevel <= 1'b0;
            capPrev <= 1'b0;
        end else if (clkEn) begin
            moduleModeReg <= next_moduleModeReg;
            cmpVal <= next_cmpVal;
            count <= next_count;
            capVal <= next_capVal;
            status <= next_status;
            mask <= next_mask;
            ack <= next_ack;
            rdData <= next_rdData;
            pinLevel <= next_pinLevel;
            capPrev <= next_capPrev;
        end
    end

    // --------------------------------------------------
    // outputs
    // --------------------------------------------------
    assign wb_ack_o = ack;
    assign wb_dat_o = rdData;
    assign moduleOutputPin = pinLevel;

    // --------------------------------------------------
    // interrupt
    // --------------------------------------------------
    // flag interrupt gating
    assign cmpReq = compareFlag && moduleModeReg.flagIrqEnable && mask[0];
    // capture flag has no mode-register enable, only its mask bit
    assign capReq = status[1] && mask[1];
    assign irq = cmpReq || capReq;
endmodule

// ===== ccm_defines.svh
// Purpose: constants for the capture/compare module mode control
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: registers sit in aligned words; mask shares the mode word, capVal the cmpVal word
`ifndef CCM_DEFINES_SVH
`define CCM_DEFINES_SVH
`define ADDR_MODE 4'h0
`define ADDR_CMPVAL 4'h4
`define ADDR_COUNT 4'h8
`define ADDR_STATUS 4'hc
`define ADDR_MASK 4'h0
`define ADDR_CAPVAL 4'h4
`define BIT_FLAG_IRQ_EN 0
`define BIT_PWM_EN 1
`define BIT_TOGGLE_EN 2
`define BIT_MATCH_EN 3
`define BIT_FALL_CAP_EN 4
`define BIT_RISE_CAP_EN 5
`define BIT_PWM_WIDE 6
`define BIT_COUNT_RUN 7
`define RST_MODE 8'h00
`define RST_CMPVAL 16'h0000
`define RST_COUNT 16'h0000
`define RST_CAPVAL 16'h0000
`define RST_STATUS 2'h0
`define RST_MASK 2'h0
`define PWM_TOP_WIDE 16'hffff
`define PWM_TOP_NARROW 8'hff
`endif

// ===== ccm_pkg.sv
// Purpose: types for the capture/compare module
// Assumes: nothing
// Notes: mode decoded from toggle and pwm enables
package ccm_pkg;
    typedef struct packed {
        logic countRun;
        logic pwmWide;
        logic riseCapEn;
        logic fallCapEn;
        logic matchEnable;
        logic toggleEnable;
        logic pwmEnable;
        logic flagIrqEnable;
    } mode_reg_t;
    typedef enum logic [3:0] {
        OUT_IDLE = 4'h1,
        OUT_TOGGLE = 4'h2,
        OUT_PWM = 4'h4,
        OUT_FREQ = 4'h8
    } out_mode_t;
endpackage

// ===== ccm_match.sv
// Purpose: one-per-update compare of counter and module value
// Assumes: counter update is a one-cycle strobe
// Notes: low-byte compare used for 8-bit pwm
`timescale 1ns/1ps
module ccm_match
    import ccm_pkg::*;
(
    input wire logic sysClk,
    input wire logic sysRst,
    input wire logic clkEn,
    input wire logic tick,
    input wire logic [15:0] count,
    input wire logic [15:0] value,
    output logic fullHit,
    output logic lowHit
);
    logic next_fullHit;
    logic next_lowHit;
    always_comb begin
        next_fullHit = tick && (count == value);
        next_lowHit = tick && (count[7:0] == value[7:0]);
    end
    always_ff @(posedge sysClk) begin
        if (sysRst) begin
            fullHit <= 1'b0;
            lowHit <= 1'b0;
        end else if (clkEn) begin
            fullHit <= next_fullHit;
            lowHit <= next_lowHit;
        end
    end
endmodule

// ===== ccm_top_properties.sv
// Purpose: port checks for the capture/compare block
// Assumes: one clock, sync reset, clkEn high in a reset
// Notes: sees only the top ports
`timescale 1ns/1ps
`include "ccm_defines.svh"
module ccm_top_properties
    import ccm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic captureIn,
    input wire logic moduleOutputPin,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic take;
    logic modeWr;
    logic quiet;
    logic next_quiet;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
    assign modeWr = take && wb_we_i && wb_adr_i == `ADDR_MODE && wb_sel_i[0];
    sequence rdOdd;
        take && !wb_we_i && wb_adr_i[1:0] != 2'b00;
    endsequence
    sequence rdStatus;
        take && !wb_we_i && wb_adr_i == `ADDR_STATUS;
    endsequence
    // ----------------------------------------
    // quiet: toggle and pwm both off
    // ----------------------------------------
    always_comb begin
        next_quiet = modeWr ? wb_dat_i[2:1] == 2'b00 : quiet;
    end
    always_ff @(posedge sys_clk) begin
        quiet <= sys_rst ? 1'b1 : next_quiet;
    end
    ack_after_take_a: assert property (take |=> wb_ack_o)
        else $error("no ack one cycle after request");
    ack_one_cycle_a: assert property (wb_ack_o && clkEn |=> !wb_ack_o)
        else $error("ack held too long");
    ack_has_cause_a: assert property ($rose(wb_ack_o) |-> $past(take))
        else $error("ack without request");
    reset_quiet_a: assert property (disable iff (1'b0)
        sys_rst && clkEn |=> !irq && !moduleOutputPin && !wb_ack_o)
        else $error("outputs active after reset");
    irq_masked_a: assert property (modeWr && wb_sel_i[2]
        && !wb_dat_i[0] && wb_dat_i[17:16] == 2'b00 |=> !irq)
        else $error("interrupt while masked");
    odd_read_zero_a: assert property (rdOdd ##1 wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    status_width_a: assert property (rdStatus ##1 wb_ack_o |-> wb_dat_o[31:2] == 30'h0)
        else $error("status has stray bits");
    pin_hold_a: assert property (quiet && $past(quiet) && $past(quiet, 2)
        |-> $stable(moduleOutputPin))
        else $error("pin moved with toggle and pwm off");
    freeze_hold_a: assert property (!clkEn |=> $stable(wb_ack_o) && $stable(wb_dat_o)
        && $stable(moduleOutputPin) && $stable(irq))
        else $error("state moved with clock enable low");
endmodule

// ===== ccm_load.sv
// Purpose: external load on the module output pin
// Assumes: pin is 0 out of reset
// Notes: counts level changes only
`timescale 1ns/1ps
module ccm_load (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic pin,
    output logic [7:0] edges
);
    logic last;
    logic [7:0] next_edges;
    always_comb begin
        next_edges = edges + {7'h0, pin != last};
    end
    always_ff @(posedge sys_clk) begin
        last <= sys_rst ? 1'b0 : pin;
        edges <= sys_rst ? 8'h0 : next_edges;
    end
endmodule

// ===== ccm_top_tb.sv
// Purpose: bench for the capture/compare mode control
// Assumes: reads noted in a queue, checked at ack
// Notes: each mode row starts from a fresh reset
`timescale 1ns/1ps
module ccm_top_tb
    import ccm_pkg::*;
;
    localparam logic [7:0] modeTab [4] = '{8'h84, 8'h86, 8'h82, 8'hc2};
    localparam logic [15:0] startTab [4] = '{16'h0, 16'h0, 16'h1000, 16'h1000};
    localparam logic [15:0] cmpTab [4] = '{16'h20, 16'h20, 16'h10f0, 16'h10f0};
    localparam logic [7:0] edgeTab [4] = '{8'h1, 8'h2, 8'h2, 8'h1};
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic capIn = 1'b0;
    logic clkEn = 1'b1;
    logic [3:0] sel = 4'hf;
    logic [3:0] selReq = 4'hf;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic pin;
    logic irq;
    logic [7:0] edges;
    logic [31:0] expQ [$];
    int error_cnt = 0;
    int checks_done = 0;
    ccm_top i_ccm_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .captureIn(capIn), .moduleOutputPin(pin), .irq(irq));
    ccm_load i_ccm_load (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin(pin), .edges(edges));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic final_report;
        $display("mismatches %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] a, input logic [31:0] e);
        checks_done++;
        if (a !== e) begin
            $display("unexpected %0t got %h want %h", $time, a, e);
            error_cnt++;
        end
    endtask
    task automatic chk_bit(input logic a, input logic e);
        checks_done++;
        if (a !== e) begin
            $display("unexpected %0t level %b want %b", $time, a, e);
            error_cnt++;
        end
    endtask
    // a read's note is taken off when its ack shows
    always @(posedge sys_clk) begin
        if (ack === 1'b1 && we === 1'b0)
            cmp(rdat, expQ.pop_front());
    end
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we, sel, adr, dat} <= {2'b11, w, selReq, a, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            $display("unexpected %0t no ack within 20 cycles", $time);
            error_cnt++;
            final_report();
        end
        {cyc, stb} <= 2'b00;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        expQ.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic rst;
        sys_rst <= 1'b1;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
    endtask
    initial begin
        logic [15:0] v;
        void'($urandom(32'ha8de));
        rst();
        rd(4'h0, 32'h0);
        rd(4'h3, 32'h0);
        v = 16'(16 + $urandom % 32);
        wb(1'b1, 4'h4, {16'h0, v});
        rd(4'h4, {16'h0, v});
        wb(1'b1, 4'h0, 32'h0001_0089);
        repeat (v + 10) begin
            @(posedge sys_clk);
            capIn <= 1'($urandom);
        end
        chk_bit(irq, 1'b1);
        rd(4'hc, 32'h1);
        selReq = 4'h4;
        wb(1'b1, 4'h0, 32'h0000_0000);
        selReq = 4'hf;
        chk_bit(irq, 1'b0);
        rd(4'h0, 32'h0000_0089);
        wb(1'b1, 4'h0, 32'h0001_0008);
        chk_bit(irq, 1'b0);
        wb(1'b1, 4'hc, 32'h1);
        rd(4'hc, 32'h0);
        wb(1'b1, 4'h0, 32'h0002_0090);
        capIn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        capIn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(4'hc, 32'h2);
        wb(1'b1, 4'hc, 32'h2);
        rd(4'hc, 32'h0);
        wb(1'b1, 4'h0, 32'h0002_00a0);
        capIn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(4'hc, 32'h2);
        for (int i = 0; i < 4; i++) begin
            rst();
            wb(1'b1, 4'h4, {16'h0, cmpTab[i]});
            wb(1'b1, 4'h8, {16'h0, startTab[i]});
            wb(1'b1, 4'h0, {24'h0, modeTab[i]});
            repeat (310) @(posedge sys_clk);
            cmp({24'h0, edges}, {24'h0, edgeTab[i]});
            chk_bit(pin, edgeTab[i][0]);
        end
        rst();
        wb(1'b1, 4'h8, 32'h0000_0100);
        wb(1'b1, 4'h0, 32'h0000_0080);
        clkEn <= 1'b0;
        repeat (50) @(posedge sys_clk);
        clkEn <= 1'b1;
        rd(4'h8, 32'h0000_0102);
        final_report();
    end
endmodule
bind ccm_top ccm_top_properties i_ccm_top_properties (.sys_clk, .sys_rst, .clkEn, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .captureIn,
    .moduleOutputPin, .irq);
